/* File: verilog/adc_serial_data_ready_port.sv */
// Serial register port and data-ready signalling of the converter.
// Assumes the filter delivers words on clk; the host drives sclk, cs_n and din.
`default_nettype none

module adc_serial_data_ready_port #(
  parameter int CAL_CYCLES = adc_port_pkg::CAL_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire adc_port_pkg::word_t word_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic data_ready_n,
  output logic cal_busy
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  adc_port_pkg::ser_state_t ser_state_reg;
  adc_port_pkg::rdy_state_t rdy_state_reg;
  logic [4:0] bit_cnt_reg;
  logic [6:0] in_shift_reg;
  logic [7:0] comm_reg;
  logic [7:0] setup_reg;
  logic [7:0] clock_reg;
  logic [15:0] out_shift_reg;
  logic [4:0] rd_len_reg;
  logic rd_data_reg;
  logic rd_tgl_reg;
  logic cal_tgl_reg;
  logic dout_reg;
  logic [7:0] byte_next;
  logic [1:0] comm_sel_next;
  logic [1:0] wr_sel;
  logic [15:0] sel_word;
  logic comm_done;
  logic wr_done;
  logic rd_last;
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] sync3_reg;
  logic rd_pulse;
  logic cal_pulse;
  logic [15:0] data_reg;
  logic [15:0] pend_data_reg;
  logic pend_valid_reg;
  logic [adc_port_pkg::CNT_W-1:0] cnt_reg;
  logic data_ready_n_reg;
  logic hold_end;
  logic cal_end;

  // ----------------------------------------
  // Serial side decode
  // ----------------------------------------
  assign byte_next = {in_shift_reg, din};
  assign comm_sel_next = byte_next[adc_port_pkg::COMM_SEL_LSB +: 2];
  assign wr_sel = comm_reg[adc_port_pkg::COMM_SEL_LSB +: 2];
  assign comm_done = (ser_state_reg == adc_port_pkg::SER_COMM) && (bit_cnt_reg == 5'h07);
  assign wr_done = (ser_state_reg == adc_port_pkg::SER_WRITE) && (bit_cnt_reg == 5'h07);
  assign rd_last = (ser_state_reg == adc_port_pkg::SER_READ) && (bit_cnt_reg == rd_len_reg);

  // Data register is read across domains without a handshake; it is quiet because
  // the host reads it only while data_ready_n is low.
  always_comb begin
    sel_word = 16'h0000;
    if (comm_sel_next == adc_port_pkg::SEL_DATA) begin
      sel_word = data_reg;
    end else if (comm_sel_next == adc_port_pkg::SEL_SETUP) begin
      sel_word = {setup_reg, 8'h00};
    end else if (comm_sel_next == adc_port_pkg::SEL_CLOCK) begin
      sel_word = {clock_reg, 8'h00};
    end else begin
      sel_word = {byte_next, 8'h00};
    end
  end

  // ----------------------------------------
  // Serial framing
  // ----------------------------------------
  // A high chip select clears the frame at once, so a lost bit never skews later bytes.
  always_ff @(posedge sclk or negedge rst_n or posedge cs_n) begin
    if (!rst_n) begin
      ser_state_reg <= adc_port_pkg::SER_COMM;
      bit_cnt_reg <= 5'h00;
      in_shift_reg <= 7'h00;
    end else if (cs_n) begin
      ser_state_reg <= adc_port_pkg::SER_COMM;
      bit_cnt_reg <= 5'h00;
      in_shift_reg <= 7'h00;
    end else begin
      in_shift_reg <= byte_next[6:0];
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
      case (ser_state_reg)
        adc_port_pkg::SER_COMM: begin
          if (comm_done) begin
            bit_cnt_reg <= 5'h00;
            ser_state_reg <= byte_next[adc_port_pkg::COMM_READ_BIT] ?
                             adc_port_pkg::SER_READ : adc_port_pkg::SER_WRITE;
          end
        end
        adc_port_pkg::SER_WRITE: begin
          if (wr_done) begin
            bit_cnt_reg <= 5'h00;
            ser_state_reg <= adc_port_pkg::SER_COMM;
          end
        end
        adc_port_pkg::SER_READ: begin
          if (rd_last) begin
            bit_cnt_reg <= 5'h00;
            ser_state_reg <= adc_port_pkg::SER_COMM;
          end
        end
        default: begin
          ser_state_reg <= adc_port_pkg::SER_COMM;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Serial registers and output shifter
  // ----------------------------------------
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      comm_reg <= adc_port_pkg::COMM_RST;
      setup_reg <= adc_port_pkg::SETUP_RST;
      clock_reg <= adc_port_pkg::CLOCK_RST;
      cal_tgl_reg <= 1'b0;
    end else if (!cs_n) begin
      if (comm_done) begin
        comm_reg <= byte_next;
      end else if (wr_done) begin
        if (wr_sel == adc_port_pkg::SEL_SETUP) begin
          setup_reg <= byte_next;
          if (byte_next[adc_port_pkg::SETUP_CAL_BIT]) begin
            cal_tgl_reg <= ~cal_tgl_reg;
          end
        end else if (wr_sel == adc_port_pkg::SEL_CLOCK) begin
          clock_reg <= byte_next;
        end else if (wr_sel == adc_port_pkg::SEL_COMM) begin
          comm_reg <= byte_next;
        end
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      out_shift_reg <= 16'h0000;
      rd_len_reg <= 5'h07;
      rd_data_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
    end else if (!cs_n) begin
      if (comm_done && byte_next[adc_port_pkg::COMM_READ_BIT]) begin
        out_shift_reg <= sel_word;
        rd_data_reg <= (comm_sel_next == adc_port_pkg::SEL_DATA);
        rd_len_reg <= (comm_sel_next == adc_port_pkg::SEL_DATA) ? 5'h0F : 5'h07;
      end else if (ser_state_reg == adc_port_pkg::SER_READ) begin
        out_shift_reg <= {out_shift_reg[14:0], 1'b0};
        if (rd_last && rd_data_reg) begin
          rd_tgl_reg <= ~rd_tgl_reg;
        end
      end
    end
  end

  // Output changes on the falling edge so the host samples a settled bit on the rising one
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      dout_reg <= 1'b0;
    end else begin
      dout_reg <= out_shift_reg[15];
    end
  end

  assign dout = dout_reg;

  // ----------------------------------------
  // Event crossing into the master clock
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      sync3_reg <= 2'h0;
    end else if (ce) begin
      sync1_reg <= {cal_tgl_reg, rd_tgl_reg};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign rd_pulse = sync2_reg[0] ^ sync3_reg[0];
  assign cal_pulse = sync2_reg[1] ^ sync3_reg[1];

  // ----------------------------------------
  // Pending word capture
  // ----------------------------------------
  // A word arriving during the load is kept for the next update; a word arriving while one is pending replaces it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_valid_reg <= 1'b0;
      pend_data_reg <= adc_port_pkg::DATA_RST;
    end else if (ce) begin
      if (word_in.valid) begin
        pend_valid_reg <= 1'b1;
        pend_data_reg <= word_in.data;
      end else if (rdy_state_reg == adc_port_pkg::RDY_LOAD) begin
        pend_valid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Data-ready sequencer
  // ----------------------------------------
  assign hold_end = (cnt_reg == adc_port_pkg::CNT_W'(adc_port_pkg::HOLD_CYCLES - 1));
  assign cal_end = (cnt_reg == adc_port_pkg::CNT_W'(CAL_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_state_reg <= adc_port_pkg::RDY_IDLE;
      cnt_reg <= '0;
      data_reg <= adc_port_pkg::DATA_RST;
      data_ready_n_reg <= 1'b1;
    end else if (ce) begin
      case (rdy_state_reg)
        adc_port_pkg::RDY_IDLE: begin
          cnt_reg <= '0;
          if (rd_pulse) begin
            data_ready_n_reg <= 1'b1;
          end
          if (cal_pulse) begin
            data_ready_n_reg <= 1'b1;
            rdy_state_reg <= adc_port_pkg::RDY_CAL;
          end else if (pend_valid_reg && (data_ready_n_reg || rd_pulse)) begin
            rdy_state_reg <= adc_port_pkg::RDY_LOAD;
          end else if (pend_valid_reg) begin
            data_ready_n_reg <= 1'b1;
            rdy_state_reg <= adc_port_pkg::RDY_HOLD;
          end
        end
        adc_port_pkg::RDY_HOLD: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (hold_end) begin
            rdy_state_reg <= adc_port_pkg::RDY_LOAD;
          end
        end
        adc_port_pkg::RDY_LOAD: begin
          data_reg <= pend_data_reg;
          data_ready_n_reg <= 1'b0;
          rdy_state_reg <= adc_port_pkg::RDY_IDLE;
        end
        adc_port_pkg::RDY_CAL: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cal_end) begin
            data_ready_n_reg <= 1'b0;
            rdy_state_reg <= adc_port_pkg::RDY_IDLE;
          end
        end
        default: begin
          rdy_state_reg <= adc_port_pkg::RDY_IDLE;
        end
      endcase
    end
  end

  assign data_ready_n = data_ready_n_reg;
  assign cal_busy = (rdy_state_reg == adc_port_pkg::RDY_CAL);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  read_release_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && rd_pulse && (rdy_state_reg == adc_port_pkg::RDY_IDLE) && !cal_pulse && !pend_valid_reg
    |=> data_ready_n)
    else $error("data ready not released after a full read");

  hold_high_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (rdy_state_reg == adc_port_pkg::RDY_HOLD) |-> data_ready_n)
    else $error("data ready low during update hold");

  hold_length_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && (rdy_state_reg == adc_port_pkg::RDY_HOLD)
    |-> (cnt_reg < adc_port_pkg::CNT_W'(adc_port_pkg::HOLD_CYCLES))
        and (hold_end |=> rdy_state_reg == adc_port_pkg::RDY_LOAD))
    else $error("update hold length wrong");

  load_low_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && (rdy_state_reg == adc_port_pkg::RDY_LOAD)
    |=> !data_ready_n && (data_reg == $past(pend_data_reg)))
    else $error("new word not announced");

  update_after_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(data_ready_n) |-> $past(rdy_state_reg) inside {adc_port_pkg::RDY_LOAD,
                                                        adc_port_pkg::RDY_CAL})
    else $error("data ready fell without update or calibration end");

  cal_done_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && (rdy_state_reg == adc_port_pkg::RDY_CAL) && cal_end
    |=> !data_ready_n && !cal_busy)
    else $error("calibration end not announced");

  sel_load_a: assert property (
    @(posedge sclk) disable iff (!rst_n || cs_n)
    comm_done && byte_next[adc_port_pkg::COMM_READ_BIT]
    |=> (out_shift_reg == $past(sel_word)) && (ser_state_reg == adc_port_pkg::SER_READ))
    else $error("output shifter loaded from wrong register");

  write_target_a: assert property (
    @(posedge sclk) disable iff (!rst_n)
    !cs_n && wr_done && (wr_sel == adc_port_pkg::SEL_DATA)
    |=> $stable(setup_reg) && $stable(clock_reg) && $stable(comm_reg))
    else $error("write to data register changed a register");

  msb_first_a: assert property (
    @(posedge sclk) disable iff (!rst_n || cs_n)
    (ser_state_reg == adc_port_pkg::SER_READ)
    |=> out_shift_reg == {$past(out_shift_reg[14:0]), 1'b0})
    else $error("serial word not shifted msb first");

  frame_idle_a: assert property (
    @(negedge cs_n) disable iff (!rst_n)
    (bit_cnt_reg == 5'h00) && (ser_state_reg == adc_port_pkg::SER_COMM))
    else $error("frame not cleared by chip select");

endmodule

`default_nettype wire

/* File: verilog/adc_port_pkg.sv */
// Constants, field positions, reset values and types for the converter serial port.
// Assumes one master clock domain and one host-driven serial clock domain.
//
// Behaviour
// - data_ready_n goes low once a fresh conversion word sits in the data register.
// - data_ready_n returns high as soon as the host has read one full data word.
// - if the old word was never read, data_ready_n goes high for 500 master cycles before the update.
// - once the data register update is done, data_ready_n goes low again.
// - data_ready_n also goes low to announce the end of a calibration sequence.
// - the output shift register loads from the comms, setup, clock or data register picked by comms.
// - a shifted-in word goes to the setup, clock or comms register picked by comms, never to data.
// - chip select is active low, enables the port, and may be tied low or frame each transfer.
// - a low reset returns control, interface, calibration and filter state to power-on values.
`default_nettype none

package adc_port_pkg;

  // ----------------------------------------
  // Widths and register selection
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 16;
  localparam logic [1:0] SEL_COMM = 2'h0;
  localparam logic [1:0] SEL_SETUP = 2'h1;
  localparam logic [1:0] SEL_CLOCK = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  localparam int COMM_SEL_LSB = 4;
  localparam int COMM_READ_BIT = 3;
  localparam int SETUP_CAL_BIT = 6;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] COMM_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h01;
  localparam logic [7:0] CLOCK_RST = 8'h05;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // ----------------------------------------
  // Timing, in master clock cycles
  // ----------------------------------------
  localparam int HOLD_MCLK_CYCLES = 500;
  localparam int MCLK_PER_CLK = 1;
  localparam int HOLD_CYCLES = HOLD_MCLK_CYCLES * MCLK_PER_CLK;
  localparam int CAL_CYCLES_DEF = 2000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } word_t;

  typedef enum logic [2:0] {
    SER_COMM = 3'b001,
    SER_WRITE = 3'b010,
    SER_READ = 3'b100
  } ser_state_t;

  typedef enum logic [3:0] {
    RDY_IDLE = 4'b0001,
    RDY_HOLD = 4'b0010,
    RDY_LOAD = 4'b0100,
    RDY_CAL = 4'b1000
  } rdy_state_t;

endpackage

`default_nettype wire

/* File: bench/host_serial_model.sv */
// Host side of the serial port: drives sclk, cs_n and din, samples dout.
// Assumes the bench calls xfer by hierarchical name, one frame at a time.
`default_nettype none

module host_serial_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;

  // Set by the bench to keep chip select low between frames (3-wire use)
  logic keep_cs = 1'b0;

  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b1;
  end

  // Comm byte then nbits; abort_at above zero drops chip select after that many bits
  task automatic xfer(input logic [7:0] comm, input logic [15:0] wd, input int nbits,
                      input int abort_at, output logic [15:0] rd);
    logic [23:0] sh;
    int n;
    sh = {comm, wd << (16 - nbits)};
    rd = '0;
    n = (abort_at > 0) ? abort_at : 8 + nbits;
    cs_n = 1'b0;
    #62.5;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din = sh[23 - i];
      #62.5;
      rd = {rd[14:0], dout};
      sclk = 1'b1;
      #62.5;
    end
    if (!keep_cs) begin
      cs_n = 1'b1;
      din = ~din; // Released line must not look like the last bit
      // Keep chip select high a while so the next frame never glitches it
      #62.5;
    end
  endtask
endmodule

`default_nettype wire

/* File: bench/adc_serial_data_ready_port_test.sv */
// Self-checking bench for the converter serial port and data-ready output.
// Assumes host_serial_model stands at the serial pins; data reads only while ready is low.
`default_nettype none

module adc_serial_data_ready_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  adc_port_pkg::word_t word_in = '0;
  logic sclk, cs_n, din, dout, data_ready_n, cal_busy;
  logic [15:0] rd;
  int n;
  int err_total = 0;
  int n_compared = 0;

  always #20 clk = ~clk;

  adc_serial_data_ready_port #(.CAL_CYCLES(CAL)) i_dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .word_in(word_in), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .data_ready_n(data_ready_n), .cal_busy(cal_busy));
  host_serial_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic rreg(input logic [1:0] sel, output logic [15:0] v);
    logic [15:0] t;
    i_host.xfer({2'b00, sel, 4'b1000}, 16'h0000, (sel == adc_port_pkg::SEL_DATA) ? 16 : 8, 0, t);
    v = (sel == adc_port_pkg::SEL_DATA) ? t : {8'h00, t[7:0]};
  endtask

  task automatic wreg(input logic [1:0] sel, input logic [7:0] v);
    logic [15:0] t;
    i_host.xfer({2'b00, sel, 4'b0000}, {8'h00, v}, 8, 0, t);
  endtask

  task automatic push(input logic [15:0] v);
    @(posedge clk) #1;
    word_in = '{valid: 1'b1, data: v};
    @(posedge clk) #1;
    word_in.valid = 1'b0;
  endtask

  // Counts clk edges until data_ready_n shows lvl, giving up after lim
  task automatic wait_rdy(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (data_ready_n !== lvl && cnt < lim) begin
      @(posedge clk) #1;
      cnt++;
    end
    check("ready level", {15'h0, lvl}, {15'h0, data_ready_n});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rreg(adc_port_pkg::SEL_SETUP, rd);
    check("setup reset", {8'h00, adc_port_pkg::SETUP_RST}, rd);
    rreg(adc_port_pkg::SEL_CLOCK, rd);
    check("clock reset", {8'h00, adc_port_pkg::CLOCK_RST}, rd);
    wreg(adc_port_pkg::SEL_CLOCK, 8'hA5);
    wreg(adc_port_pkg::SEL_SETUP, 8'h12);
    rreg(adc_port_pkg::SEL_CLOCK, rd);
    check("clock write", 16'h00A5, rd);
    rreg(adc_port_pkg::SEL_SETUP, rd);
    check("setup write", 16'h0012, rd);
    rreg(adc_port_pkg::SEL_COMM, rd);
    check("comm read", {8'h00, 2'b00, adc_port_pkg::SEL_COMM, 4'b1000}, rd);
  endtask

  // Chip select tied low: frames follow each other with no framing pulse
  task automatic t_three;
    i_host.keep_cs = 1'b1;
    wreg(adc_port_pkg::SEL_CLOCK, 8'h3C);
    rreg(adc_port_pkg::SEL_CLOCK, rd);
    i_host.keep_cs = 1'b0;
    check("clock in 3-wire mode", 16'h003C, rd);
  endtask

  task automatic t_abort;
    i_host.xfer(8'h10, 16'h0033, 8, 12, rd);
    rreg(adc_port_pkg::SEL_SETUP, rd);
    check("setup after abort", 16'h0012, rd);
  endtask

  task automatic t_word;
    push(16'hA53C);
    wait_rdy(1'b0, 10, n);
    check("ready low on word", 16'h0000, {15'h0, data_ready_n});
    wreg(adc_port_pkg::SEL_DATA, 8'hFF);
    rreg(adc_port_pkg::SEL_DATA, rd);
    check("data word", 16'hA53C, rd);
    wait_rdy(1'b1, 10, n);
    check("ready high after read", 16'h0001, {15'h0, data_ready_n});
  endtask

  task automatic t_hold;
    push(16'h1111);
    wait_rdy(1'b0, 10, n);
    push(16'h2222);
    wait_rdy(1'b1, 10, n);
    wait_rdy(1'b0, 600, n);
    check("hold length ok", 16'h0001, {15'h0, n >= 500 && n <= 503});
    check("ready low after update", 16'h0000, {15'h0, data_ready_n});
    rreg(adc_port_pkg::SEL_DATA, rd);
    check("newest word", 16'h2222, rd);
    wait_rdy(1'b1, 10, n);
  endtask

  task automatic t_ce;
    @(posedge clk) #1;
    ce = 1'b0;
    push(16'h3333);
    repeat (10) @(posedge clk);
    #1 ce = 1'b1;
    repeat (10) @(posedge clk);
    check("frozen word ignored", 16'h0001, {15'h0, data_ready_n});
  endtask

  task automatic t_cal;
    wreg(adc_port_pkg::SEL_SETUP, 8'h40);
    n = 0;
    while (cal_busy !== 1'b1 && n < 20) begin
      @(posedge clk) #1;
      n++;
    end
    check("cal started", 16'h0001, {15'h0, cal_busy & data_ready_n});
    wait_rdy(1'b0, CAL + 20, n);
    check("cal length ok", 16'h0001, {15'h0, n >= CAL - 2 && n <= CAL + 3});
    check("cal busy cleared", 16'h0000, {15'h0, cal_busy});
  endtask

  task automatic t_reset;
    wreg(adc_port_pkg::SEL_CLOCK, 8'h5A);
    @(posedge clk) #1;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    check("ready in reset", 16'h0001, {15'h0, data_ready_n});
    #1 rst_n = 1'b1;
    rreg(adc_port_pkg::SEL_CLOCK, rd);
    check("clock after reset", {8'h00, adc_port_pkg::CLOCK_RST}, rd);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    t_regs();
    t_abort();
    t_three();
    t_word();
    t_hold();
    t_ce();
    t_cal();
    t_reset();
    test_done();
  end

  // Whole run needs about 1500 clk cycles
  initial begin
    #400us;
    err_total++;
    test_done();
  end
endmodule

`default_nettype wire
